// ==== rtl/eba_access_unit.sv ====
// byte-wide nonvolatile cell access unit with apb register port
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "eba_regs.svh"

// How it works
// - a read strobe fetches the byte at the cell address into the data register through the registered cell read, two edges later.
// - each accepted read strobe stalls the core for four cycles; a refused read does not stall it.
// - while programming, reads are refused and address writes ignored.
// - programming time is counted as 26368 rc oscillator cycles.
// - a reset during a cell write does not abort the write.
// - the arm bit self-clears after four cycles and gates the write strobe.
// - the write strobe bit clears itself when programming time has elapsed.
// - the mode field picks atomic, erase-only or write-only and is frozen while writing.
// - the ready interrupt stays asserted while the write strobe bit is clear and enabled.
module eba_access_unit
#(
    parameter int AW        = 11,
    parameter int RC_CYCLES = `EBA_RC_CYCLES
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output var  logic [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // calibrated rc oscillator tick, one pclk cycle per rc cycle
    input  wire logic        rc_tick,
    // program-memory store busy, blocks a new write start
    input  wire logic        store_busy,
    // core stall and interrupts
    output logic             core_stall,
    output logic             ready_irq,
    output logic             irq
);
    import eba_pkg::*;

    // the address split needs a full low byte and the rc counter is only 16 bits wide
    if (AW < 8 || AW > 16 || RC_CYCLES < 1 || RC_CYCLES > 65536)
    begin : g_bad_param
        $error("eba_access_unit: unsupported parameters");
    end

    localparam logic [15:0] RC_LAST = 16'(RC_CYCLES - 1);

    eba_state_e        state_ff;
    logic [AW-1:0]     addr_ff;
    logic [7:0]        data_ff;
    logic              arm_ff;
    logic [2:0]        arm_cnt_ff;
    logic              rdyie_ff;
    eba_mode_e         mode_ff;
    eba_mode_e         prog_mode_ff;
    logic [15:0]       rc_cnt_ff;
    logic [2:0]        stall_cnt_ff;
    logic [1:0]        status_ff;
    logic [1:0]        mask_ff;
    logic [AW-1:0]     prog_addr_ff;
    logic [7:0]        prog_data_ff;
    logic [7:0]        mem_rdata;
    logic              rd_land_ff;
    logic              prog_seen_ff;

    logic              acc;
    logic              wr;
    logic              wr_ctrl;
    logic              busy;
    logic              rd_go;
    logic              rd_refused;
    logic              wr_go;
    logic              prog_end;
    logic              nxt_done;
    logic [31:0]       nxt_prdata;
    logic              cut_wr;
    logic              cell_we;

    // zero wait state slave, every access completes in its first access cycle
    assign pready  = 1'b1;
    assign acc     = psel & penable;
    assign wr      = acc & pwrite & pstrb[0];
    assign wr_ctrl = wr && paddr == `EBA_OFF_CTRL;
    assign busy    = state_ff == EBA_PROG;

    // unmapped address answers with an error
    always_comb
    begin
        pslverr = 1'b0;
        if (acc)
        begin
            pslverr = !(paddr == `EBA_OFF_CTRL || paddr == `EBA_OFF_ADDR_LO || paddr == `EBA_OFF_ADDR_HI ||
                        paddr == `EBA_OFF_DATA || paddr == `EBA_OFF_STATUS || paddr == `EBA_OFF_MASK);
        end
    end

    assign rd_go      = wr_ctrl & pwdata[`EBA_CTRL_READ] & ~busy & (state_ff != EBA_READ);
    assign rd_refused = wr_ctrl & pwdata[`EBA_CTRL_READ] & busy;
    assign wr_go      = wr_ctrl & pwdata[`EBA_CTRL_WRITE] & arm_ff & ~busy & ~store_busy & (mode_ff != EBA_PM_RSVD);
    // end after the last rc cycle
    assign prog_end   = busy & rc_tick & (rc_cnt_ff == RC_LAST);
    assign nxt_done   = prog_end;

    // stall the core for four cycles per read
    assign core_stall = stall_cnt_ff != 3'h0;
    // ready request is a level while idle of writes
    assign ready_irq  = rdyie_ff & ~busy;
    assign irq        = |(status_ff & mask_ff);

    // sequencer state; the visible busy state clears on reset, a cut write is landed below
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff <= EBA_IDLE;
        end
        else if (wr_go)
        begin
            state_ff <= EBA_PROG;
        end
        else if (prog_end)
        begin
            state_ff <= EBA_IDLE;
        end
        else if (rd_go)
        begin
            state_ff <= EBA_READ;
        end
        else if (state_ff == EBA_READ && stall_cnt_ff == 3'h1)
        begin
            state_ff <= EBA_IDLE;
        end
    end

    // rc cycle counter, cleared at each new write
    always_ff @(posedge pclk)
    begin
        if (wr_go)
        begin
            rc_cnt_ff <= 16'h0000;
        end
        else if (busy && rc_tick)
        begin
            rc_cnt_ff <= rc_cnt_ff + 16'h0001;
        end
    end

    // the programmed cell and data are latched without reset so a reset cannot corrupt them
    always_ff @(posedge pclk)
    begin
        if (wr_go)
        begin
            prog_addr_ff <= addr_ff;
            prog_data_ff <= data_ff;
            prog_mode_ff <= mode_ff;
        end
    end

    // remembers a run at the last edge; no reset, so it outlives the reset that cuts the run
    always_ff @(posedge pclk)
    begin
        prog_seen_ff <= busy;
    end

    // a reset in mid-run lands the byte at once; the rest of the wait is skipped, not the write
    assign cut_wr  = ~presetn & prog_seen_ff;
    assign cell_we = (prog_end | cut_wr) & (prog_mode_ff != EBA_PM_RSVD);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            addr_ff <= '0;
        end
        else if (wr && !busy && paddr == `EBA_OFF_ADDR_LO)
        begin
            addr_ff <= AW'({addr_ff[AW-1:0] >> 8, pwdata[7:0]} & ((1 << AW) - 1));
        end
        else if (wr && !busy && paddr == `EBA_OFF_ADDR_HI)
        begin
            addr_ff <= AW'(({24'h0, pwdata[7:0]} << 8 | {24'h0, addr_ff[7:0]} & 32'h0000_00FF) & ((1 << AW) - 1));
        end
    end

    // read data lands in the data register two edges after the strobe, behind the registered cell read
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            data_ff    <= 8'h00;
            rd_land_ff <= 1'b0;
        end
        else
        begin
            rd_land_ff <= rd_go;
            if (rd_land_ff)
            begin
                data_ff <= mem_rdata;
            end
            else if (wr && paddr == `EBA_OFF_DATA)
            begin
                data_ff <= pwdata[7:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stall_cnt_ff <= 3'h0;
        end
        else if (rd_go)
        begin
            stall_cnt_ff <= `EBA_RD_STALL;
        end
        else if (stall_cnt_ff != 3'h0)
        begin
            stall_cnt_ff <= stall_cnt_ff - 3'h1;
        end
    end

    // arm bit with four cycle timeout
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            arm_ff     <= 1'b0;
            arm_cnt_ff <= 3'h0;
        end
        else if (wr_ctrl && pwdata[`EBA_CTRL_ARM])
        begin
            arm_ff     <= 1'b1;
            arm_cnt_ff <= `EBA_ARM_CYCLES;
        end
        else if (arm_ff)
        begin
            arm_cnt_ff <= arm_cnt_ff - 3'h1;
            arm_ff     <= arm_cnt_ff != 3'h1;
        end
    end

    // ready interrupt enable, plain control bit
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rdyie_ff <= 1'b0;
        end
        else if (wr_ctrl)
        begin
            rdyie_ff <= pwdata[`EBA_CTRL_RDYIE];
        end
    end

    // mode frozen while writing; back to atomic in reset, one edge later if a write was running
    // limitation: after power-up the reset must span a few edges before the mode is known
    always_ff @(posedge pclk)
    begin
        if (!presetn && !prog_seen_ff)
        begin
            mode_ff <= eba_mode_e'(`EBA_PM_RESET);
        end
        else if (presetn && wr_ctrl && !busy)
        begin
            mode_ff <= eba_mode_e'(pwdata[`EBA_CTRL_PM_HI:`EBA_CTRL_PM_LO]);
        end
    end

    // sticky events, write one to clear, a new event wins over the clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            status_ff <= 2'h0;
            mask_ff   <= 2'h0;
        end
        else
        begin
            status_ff <= (status_ff & ~((wr && paddr == `EBA_OFF_STATUS) ? pwdata[1:0] : 2'h0))
                         | {rd_refused, nxt_done};
            if (wr && paddr == `EBA_OFF_MASK)
            begin
                mask_ff <= pwdata[1:0];
            end
        end
    end

    eba_cell_mem #(.AW(AW)) u_mem (
        .clk   (pclk),
        .we    (cell_we),
        .erase (prog_mode_ff == EBA_PM_ERASE),
        .waddr (prog_addr_ff),
        .wdata (prog_mode_ff == EBA_PM_WRITE ? (prog_data_ff & 8'hFF) : prog_data_ff),
        .re    (rd_go),
        .raddr (addr_ff),
        .rdata (mem_rdata)
    );

    // read mux, registered on the setup cycle
    always_comb
    begin
        nxt_prdata = 32'h0000_0000;
        unique case (paddr)
            `EBA_OFF_CTRL:    nxt_prdata = {26'h0, mode_ff, rdyie_ff, arm_ff, busy, 1'b0};
            `EBA_OFF_ADDR_LO: nxt_prdata = {24'h0, 8'(addr_ff)};
            `EBA_OFF_ADDR_HI: nxt_prdata = {24'h0, 8'(32'(addr_ff) >> 8)};
            `EBA_OFF_DATA:    nxt_prdata = {24'h0, data_ff};
            `EBA_OFF_STATUS:  nxt_prdata = {30'h0, status_ff};
            `EBA_OFF_MASK:    nxt_prdata = {30'h0, mask_ff};
            default:          nxt_prdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
        end
        else if (psel && !penable)
        begin
            prdata <= nxt_prdata;
        end
    end
endmodule : eba_access_unit
`default_nettype wire

// ==== rtl/eba_cell_mem.sv ====
// byte-wide cell array with registered read data
`timescale 1ns/1ps
`default_nettype none
module eba_cell_mem #(
    parameter int AW = 11
) (
    // clock
    input  wire logic          clk,
    // write port
    input  wire logic          we,
    input  wire logic          erase,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [7:0]    wdata,
    // read port
    input  wire logic          re,
    input  wire logic [AW-1:0] raddr,
    output var  logic [7:0]    rdata
);
    logic [7:0] mem [0:(1<<AW)-1];

    // erase drives a cell to all ones, otherwise the cell takes the write data whole
    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem[waddr] <= erase ? 8'hFF : wdata;
        end
    end

    // read data leaves through a register
    always_ff @(posedge clk)
    begin
        if (re)
        begin
            rdata <= mem[raddr];
        end
    end
endmodule : eba_cell_mem
`default_nettype wire

// ==== rtl/eba_pkg.sv ====
// types shared by the cell access unit
package eba_pkg;
    typedef enum logic [1:0] {EBA_PM_ATOMIC, EBA_PM_ERASE, EBA_PM_WRITE, EBA_PM_RSVD} eba_mode_e;
    typedef enum logic [1:0] {EBA_IDLE, EBA_READ, EBA_PROG} eba_state_e;
endpackage : eba_pkg

// ==== rtl/eba_regs.svh ====
// register offsets, field positions, reset values and timing counts of the cell access unit
`ifndef EBA_REGS_SVH
`define EBA_REGS_SVH

`define EBA_OFF_CTRL       12'h000
`define EBA_OFF_ADDR_LO    12'h004
`define EBA_OFF_ADDR_HI    12'h008
`define EBA_OFF_DATA       12'h00C
`define EBA_OFF_STATUS     12'h010
`define EBA_OFF_MASK       12'h014

`define EBA_CTRL_READ      0
`define EBA_CTRL_WRITE     1
`define EBA_CTRL_ARM       2
`define EBA_CTRL_RDYIE     3
`define EBA_CTRL_PM_LO     4
`define EBA_CTRL_PM_HI     5

`define EBA_ST_DONE        0
`define EBA_ST_REFUSED     1

`define EBA_ARM_CYCLES     3'h4
`define EBA_RD_STALL       3'h4
`define EBA_RC_CYCLES      26368
`define EBA_PM_RESET       2'h0

`endif

// ==== tb/eba_access_unit_chk.sv ====
// port assertions of the cell access unit
`timescale 1ns/1ps
`default_nettype none
module eba_access_unit_chk #(
    parameter int RC_CYCLES = 8
) (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // side signals
    input wire logic        rc_tick,
    input wire logic        core_stall,
    input wire logic        ready_irq,
    input wire logic        irq
);
    logic        ctl_wr;
    logic        prog_ff;
    logic [15:0] tick_ff;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // control write in its access cycle
    assign ctl_wr = psel && penable && pwrite && paddr == 12'h000;
    // follows one run; it starts a cycle late, so the bounds allow slack
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prog_ff <= 1'b0;
            tick_ff <= 16'h0000;
        end
        else
        begin
            prog_ff <= ($fell(ready_irq) && $past(pwdata[1])) || (prog_ff && !ready_irq);
            tick_ff <= prog_ff ? tick_ff + {15'h0000, rc_tick} : 16'h0000;
        end
    end
    sequence s_stall_run;
        core_stall [*4] ##1 !core_stall;
    endsequence
    chk_stall_four:
    assert property ($rose(core_stall) |-> s_stall_run) else $error("stall length wrong");
    chk_stall_cause:
    assert property ($rose(core_stall) |-> $past(ctl_wr && pwdata[0])) else $error("stall without strobe");
    chk_read_stalls:
    assert property (ctl_wr && pwdata[0] && ready_irq |=> core_stall) else $error("read did not stall");
    chk_ready_fall:
    assert property ($fell(ready_irq) |-> $past(ctl_wr)) else $error("ready dropped alone");
    chk_prog_len:
    assert property ($rose(ready_irq) && prog_ff |-> tick_ff + 16'h0003 >= RC_CYCLES && tick_ff <= RC_CYCLES + 1)
        else $error("program time wrong");
    chk_prog_bound:
    assert property (prog_ff |-> tick_ff <= RC_CYCLES + 1) else $error("write strobe stuck");
    chk_irq_fall:
    assert property ($fell(irq) |-> $past(psel && penable && pwrite && paddr >= 12'h010))
        else $error("irq dropped alone");
    chk_zero_wait:
    assert property (psel && penable |-> pready) else $error("wait state");
    chk_err_phase:
    assert property (pslverr |-> psel && penable) else $error("stray slverr");
endmodule : eba_access_unit_chk
bind eba_access_unit eba_access_unit_chk #(.RC_CYCLES(RC_CYCLES)) u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .rc_tick(rc_tick), .core_stall(core_stall), .ready_irq(ready_irq), .irq(irq));
`default_nettype wire

// ==== tb/eba_access_unit_test.sv ====
// register-level bench of the cell access unit
`timescale 1ns/1ps
`default_nettype none
`include "eba_regs.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_total++; $display("BAD %0t %h %h", $time, a, b); end end
module eba_access_unit_test;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic        pready, pslverr, err, rc_tick, store_busy, core_stall, ready_irq, irq;
    logic        slow = 1'b0;
    logic        store_req = 1'b0;
    int          err_total = 0;
    int          total_checks = 0;
    int          cyc = 0;
    always #25 pclk = ~pclk;
    eba_access_unit #(.RC_CYCLES(8)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rc_tick(rc_tick), .store_busy(store_busy), .core_stall(core_stall),
        .ready_irq(ready_irq), .irq(irq));
    eba_rc_model u_rc (.pclk(pclk), .slow(slow), .store_req(store_req), .rc_tick(rc_tick),
        .store_busy(store_busy));
    task automatic stop_test();
        if (err_total == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : stop_test
    // a hang ends the run as a mismatch
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            err_total++;
            stop_test();
        end
    end
    // one transfer, entered just after an edge; one idle cycle after it
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    // polls until no write runs
    task automatic wait_idle();
        do apb(1'b0, `EBA_OFF_CTRL, 32'h0); while (rd[1] !== 1'b0);
    endtask : wait_idle
    task automatic set_addr(input logic [10:0] a);
        apb(1'b1, `EBA_OFF_ADDR_LO, {24'h0, a[7:0]});
        apb(1'b1, `EBA_OFF_ADDR_HI, {29'h0, a[10:8]});
    endtask : set_addr
    task automatic cell_wr(input logic [10:0] a, input logic [7:0] d, input logic [1:0] m);
        wait_idle();
        set_addr(a);
        apb(1'b1, `EBA_OFF_DATA, {24'h0, d});
        apb(1'b1, `EBA_OFF_CTRL, {26'h0, m, 4'hC});
        apb(1'b1, `EBA_OFF_CTRL, {26'h0, m, 4'hE});
    endtask : cell_wr
    // strobe, sit out the stall, then fetch the data register
    task automatic cell_rd(input logic [7:0] e);
        apb(1'b1, `EBA_OFF_CTRL, 32'h9);
        repeat (4) @(posedge pclk);
        apb(1'b0, `EBA_OFF_DATA, 32'h0);
        `CHK(rd[7:0], e)
    endtask : cell_rd
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `EBA_OFF_CTRL, 32'h0);
        `CHK(rd, 32'h0)
        apb(1'b0, 12'h018, 32'h0);
        `CHK(err, 1'b1)
        apb(1'b1, `EBA_OFF_MASK, 32'h3);
        cell_wr(11'h5A3, 8'hA5, 2'h0);
        `CHK(ready_irq, 1'b0)
        wait_idle();
        `CHK({irq, ready_irq}, 2'h3)
        apb(1'b1, `EBA_OFF_STATUS, 32'h1);
        `CHK(irq, 1'b0)
        cell_rd(8'hA5);
        cell_wr(11'h5A3, 8'h00, 2'h1);
        wait_idle();
        apb(1'b1, `EBA_OFF_MASK, 32'h0);
        `CHK(irq, 1'b0)
        apb(1'b1, `EBA_OFF_MASK, 32'h3);
        `CHK(irq, 1'b1)
        apb(1'b1, `EBA_OFF_STATUS, 32'h1);
        cell_rd(8'hFF);
        // slow run, so every push below lands while the write still runs
        slow <= 1'b1;
        cell_wr(11'h5A3, 8'h3C, 2'h2);
        // address, mode and read all pushed while busy
        apb(1'b1, `EBA_OFF_ADDR_LO, 32'h11);
        apb(1'b1, `EBA_OFF_CTRL, 32'h1A);
        apb(1'b1, `EBA_OFF_CTRL, 32'h2B);
        apb(1'b0, `EBA_OFF_CTRL, 32'h0);
        `CHK(rd[5:4], 2'h2)
        wait_idle();
        slow <= 1'b0;
        apb(1'b0, `EBA_OFF_STATUS, 32'h0);
        `CHK(rd[1:0], 2'h3)
        apb(1'b1, `EBA_OFF_STATUS, 32'h3);
        cell_rd(8'h3C);
        // arm left to lapse before the strobe
        apb(1'b1, `EBA_OFF_CTRL, 32'hC);
        repeat (6) @(posedge pclk);
        apb(1'b0, `EBA_OFF_CTRL, 32'h0);
        `CHK(rd[2], 1'b0)
        apb(1'b1, `EBA_OFF_CTRL, 32'hA);
        apb(1'b0, `EBA_OFF_CTRL, 32'h0);
        `CHK(rd[1], 1'b0)
        // reserved mode must not start a write
        cell_wr(11'h012, 8'h99, 2'h3);
        apb(1'b0, `EBA_OFF_CTRL, 32'h0);
        `CHK(rd[1], 1'b0)
        store_req <= 1'b1;
        cell_wr(11'h012, 8'h77, 2'h0);
        apb(1'b0, `EBA_OFF_CTRL, 32'h0);
        `CHK(rd[1], 1'b0)
        store_req <= 1'b0;
        slow <= 1'b1;
        cell_wr(11'h012, 8'h5E, 2'h0);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        // busy flag is lost in reset, so wait out a slow run
        repeat (48) @(posedge pclk);
        set_addr(11'h012);
        cell_rd(8'h5E);
        stop_test();
    end
endmodule : eba_access_unit_test
`default_nettype wire

// ==== tb/eba_rc_model.sv ====
// oscillator tick and program-store busy source facing the unit
`timescale 1ns/1ps
`default_nettype none
module eba_rc_model (
    // clock and modes
    input  wire logic pclk,
    input  wire logic slow,
    input  wire logic store_req,
    // to the unit
    output logic      rc_tick,
    output logic      store_busy
);
    logic [1:0] div_ff = 2'h0;
    // free divider; the oscillator never pauses
    always_ff @(posedge pclk)
    begin
        div_ff <= div_ff + 2'h1;
    end
    assign rc_tick = slow ? (div_ff == 2'h3) : 1'b1;
    assign store_busy = store_req;
endmodule : eba_rc_model
`default_nettype wire
